// *** rtl/lerbs_bufsel.sv ***
`default_nettype none
`include "lerbs_consts.svh"
module lerbs_bufsel (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic msg_valid,
   input wire lerbs_pkg::lerbs_msg_type msg,
   input wire logic pool_en,
   input wire logic pool_quota_nz,
   input wire lerbs_pkg::lerbs_list_type pool_head,
   input wire lerbs_pkg::lerbs_list_type priv_head,
   output lerbs_pkg::lerbs_sel_type sel
);
   lerbs_pkg::lerbs_sel_type sel_r, sel_nxt;

   // only the head of each list is ever looked at [R11]
   function automatic lerbs_pkg::lerbs_sel_type decide(
      input lerbs_pkg::lerbs_msg_type m,
      input logic en,
      input logic qnz,
      input lerbs_pkg::lerbs_list_type pl,
      input lerbs_pkg::lerbs_list_type pv);
      lerbs_pkg::lerbs_sel_type s;
      logic pool_ok;
      s = '0;
      pool_ok = en && qnz && pl.avail; // [R8]
      if (!m.seq_ok) begin
         s.ignored = 1'b1; // [R7]
      end else if (pool_ok && pl.size >= m.len) begin
         s.take_pool = 1'b1; // [R8]
      end else if (pool_ok) begin
         if (!pv.avail) begin
            s.nak_small = 1'b1; // [R9]
         end else if (pv.size < m.len) begin
            s.nak_small = 1'b1; // [R9]
         end else begin
            s.take_priv = 1'b1; // [R9]
         end
      end else if (!pv.avail) begin
         s.nak_unavail = 1'b1; // [R10]
      end else if (pv.size < m.len) begin
         s.nak_small = 1'b1; // [R10]
      end else begin
         s.take_priv = 1'b1; // [R10]
      end
      decide = s;
   endfunction

   always_comb begin
      sel_nxt = '0;
      if (msg_valid) begin
         sel_nxt = decide(msg, pool_en, pool_quota_nz, pool_head, priv_head);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_r <= '0;
      end else begin
         sel_r <= sel_nxt;
      end
   end

   assign sel = sel_r;

   a_seq_ignore: assert property (@(posedge core_clk) disable iff (!rst_n)
      (msg_valid && !msg.seq_ok) |=> (sel_r.ignored && !sel_r.take_pool
      && !sel_r.take_priv && !sel_r.nak_small && !sel_r.nak_unavail))
      else $error("out of sequence message not ignored"); // [R7]
   a_pool_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
      (msg_valid && !(pool_en && pool_quota_nz && pool_head.avail))
      |=> !sel_r.take_pool)
      else $error("pool buffer taken while pool unusable"); // [R8]
   a_small_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
      (msg_valid && msg.seq_ok && pool_en && pool_quota_nz
      && pool_head.avail && pool_head.size < msg.len && !priv_head.avail)
      |=> sel_r.nak_small)
      else $error("missing buffer too small nak"); // [R9]
   a_unavail_nak: assert property (@(posedge core_clk) disable iff (!rst_n)
      (msg_valid && msg.seq_ok && !pool_en && !priv_head.avail)
      |=> (sel_r.nak_unavail && !sel_r.nak_small))
      else $error("missing temporarily unavailable nak"); // [R10]
endmodule
`default_nettype wire

// *** rtl/lerbs_consts.svh ***
`ifndef LERBS_CONSTS_SVH
`define LERBS_CONSTS_SVH
`define LERBS_CLK_HZ 50000000
`define LERBS_WIN_S 3
`define LERBS_WIN_CYC (`LERBS_WIN_S * `LERBS_CLK_HZ)
`define LERBS_INFO_LO 9'h064
`define LERBS_INFO_HI 9'h08c
`define LERBS_CODE_NXM 9'h12c
`define LERBS_CODE_BTS 9'h12e
`define LERBS_FIFO_DEPTH 8
`define LERBS_CNT_NUM 5
`define LERBS_CNT_THR 3
`define LERBS_CNT_GLB 4
`define LERBS_MAX_STAT 16'hffff
`define LERBS_MAX_ERR 16'h00ff
`define LERBS_MAX_THR 16'h0007
`define LERBS_CNT_RST 16'h0000
`endif

// *** rtl/lerbs_ctrl.sv ***
`default_nettype none
`include "lerbs_consts.svh"
// Behaviour
// [R1] counters frozen while tributary protocol halted
// [R2] codes 100 to 140 reported as info
// [R3] codes 300 and 302 marked recovery class
// [R4] host halts protocol on network errors
// [R5] bad bus address sent as control response
// [R6] reported address may be already advanced
// [R7] out of sequence messages are ignored
// [R8] pool used only if enabled, quota, available
// [R9] pool too small: try private or nak
// [R10] private path: nak unavailable, small, or use
// [R11] only the list heads are considered
// [R12] too small raised for receive buffers only
// [R13] response queue overflow forces fatal shutdown
// [R14] after overflow present response, interrupt, window
// [R15] each timely read presents next, fresh window
// [R16] shut down on last read or timeout
// [R17] halt returns outstanding tributary buffers
// [R18] host issues global halt for pool errors
// [R19] host halts before reading counters
// [R20] host halts and clears before restart
// [R21] threshold counters wrap at max, never cleared
// [R22] shut down device ignores all but startup
module lerbs_ctrl #(
   parameter int unsigned WIN_CYC = `LERBS_WIN_CYC,
   parameter int DEPTH = `LERBS_FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic host_startup,
   input wire logic host_halt,
   input wire logic host_global_halt,
   input wire logic host_resp_ack,
   input wire logic [2:0] host_cnt_sel,
   input wire logic host_cnt_clear,
   input wire logic line_msg_valid,
   input wire lerbs_pkg::lerbs_msg_type line_msg,
   input wire logic pool_en,
   input wire logic pool_quota_nz,
   input wire lerbs_pkg::lerbs_list_type pool_head,
   input wire lerbs_pkg::lerbs_list_type priv_head,
   input wire logic nxm_valid,
   input wire logic [17:0] nxm_addr,
   input wire logic proc_err_valid,
   input wire logic [8:0] proc_err_code,
   input wire logic [`LERBS_CNT_NUM-1:0] cnt_inc,
   output lerbs_pkg::lerbs_sel_type buf_sel,
   output logic resp_valid,
   output lerbs_pkg::lerbs_resp_type resp_data,
   output logic host_irq,
   output logic dev_shutdown,
   output logic ret_priv_bufs,
   output logic ret_pool_bufs,
   output logic [15:0] cnt_data
);
   localparam int TW = $clog2(WIN_CYC + 1);
   localparam int RW = $bits(lerbs_pkg::lerbs_resp_type);
   localparam int NC = `LERBS_CNT_NUM;

   lerbs_pkg::lerbs_state_type st_r, st_nxt;
   logic down_r, down_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic stage_v_r, stage_v_nxt;
   lerbs_pkg::lerbs_resp_type stage_r, stage_nxt;
   logic pres_v_r, pres_v_nxt;
   lerbs_pkg::lerbs_resp_type pres_r, pres_nxt;
   logic irq_r, irq_nxt;
   logic halt_d_r, halt_d_nxt;
   logic rpriv_r, rpriv_nxt;
   logic rpool_r, rpool_nxt;
   logic [NC-1:0][15:0] cnt_r, cnt_nxt;
   logic [15:0] cdat_r, cdat_nxt;
   logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
   logic [RW-1:0] fifo_out_bits;
   lerbs_pkg::lerbs_resp_type fifo_head;
   logic run, evt, overflow, load, bts_evt;
   lerbs_pkg::lerbs_resp_type evt_word;
   lerbs_pkg::lerbs_sel_type sel;

   function automatic lerbs_pkg::lerbs_class_type classify(
      input logic [8:0] code);
      if (code >= `LERBS_INFO_LO && code <= `LERBS_INFO_HI) begin
         classify = lerbs_pkg::LERBS_CL_INFO; // [R2]
      end else if (code == `LERBS_CODE_NXM || code == `LERBS_CODE_BTS) begin
         classify = lerbs_pkg::LERBS_CL_RECOV; // [R3]
      end else begin
         classify = lerbs_pkg::LERBS_CL_NET;
      end
   endfunction

   function automatic logic [15:0] cnt_max(input int idx);
      if (idx == `LERBS_CNT_THR) begin
         cnt_max = `LERBS_MAX_THR;
      end else if (idx < 2) begin
         cnt_max = `LERBS_MAX_STAT;
      end else begin
         cnt_max = `LERBS_MAX_ERR;
      end
   endfunction

   assign run = (st_r == lerbs_pkg::LERBS_RUN);

   lerbs_bufsel u_bufsel (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .msg_valid(line_msg_valid && run), // [R22]
      .msg(line_msg),
      .pool_en(pool_en),
      .pool_quota_nz(pool_quota_nz),
      .pool_head(pool_head),
      .priv_head(priv_head),
      .sel(sel)
   );

   lerbs_fifo #(
      .WIDTH(RW),
      .DEPTH(DEPTH)
   ) u_respq (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .flush(fifo_flush),
      .in_valid(stage_v_r),
      .in_ready(fifo_in_ready),
      .in_data(stage_r),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_bits)
   );

   assign fifo_head = lerbs_pkg::lerbs_resp_type'(fifo_out_bits);
   // receive-side selector is the only source of too small events [R12]
   assign bts_evt = sel.nak_small && run;

   always_comb begin
      evt = 1'b0;
      evt_word = '0;
      if (run) begin
         if (nxm_valid) begin
            evt = 1'b1; // [R5]
            evt_word.code = `LERBS_CODE_NXM;
            evt_word.data = nxm_addr; // passed unaltered [R6]
         end else if (bts_evt) begin
            evt = 1'b1;
            evt_word.code = `LERBS_CODE_BTS;
         end else if (proc_err_valid) begin
            evt = 1'b1;
            evt_word.code = proc_err_code;
         end
      end
      evt_word.cls = classify(evt_word.code);
   end

   // queue full and staging blocked: no link blocks left [R13]
   assign overflow = evt && stage_v_r && !fifo_in_ready;

   always_comb begin
      stage_v_nxt = stage_v_r;
      stage_nxt = stage_r;
      if (stage_v_r && fifo_in_ready) begin
         stage_v_nxt = 1'b0;
      end
      if (evt && !overflow) begin
         stage_v_nxt = 1'b1;
         stage_nxt = evt_word;
      end
      if (!run) begin
         stage_v_nxt = 1'b0;
      end
   end

   assign load = (st_r != lerbs_pkg::LERBS_DOWN) && fifo_out_valid
      && (!pres_v_r || host_resp_ack);
   assign fifo_out_ready = load;
   assign fifo_flush = (st_r == lerbs_pkg::LERBS_DOWN);

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      pres_v_nxt = pres_v_r;
      pres_nxt = pres_r;
      irq_nxt = 1'b0;
      if (load) begin
         pres_v_nxt = 1'b1;
         pres_nxt = fifo_head;
         irq_nxt = 1'b1; // [R14]
      end else if (host_resp_ack) begin
         pres_v_nxt = 1'b0;
      end
      case (st_r)
         lerbs_pkg::LERBS_RUN: begin
            if (overflow) begin
               st_nxt = lerbs_pkg::LERBS_DRAIN; // [R13]
               tmr_nxt = '0;
            end
         end
         lerbs_pkg::LERBS_DRAIN: begin
            if (load) begin
               tmr_nxt = '0; // [R15]
            end else if (pres_v_r && host_resp_ack) begin
               st_nxt = lerbs_pkg::LERBS_DOWN; // [R16]
            end else if (pres_v_r && tmr_r == TW'(WIN_CYC - 1)) begin
               st_nxt = lerbs_pkg::LERBS_DOWN; // [R16]
            end else if (pres_v_r) begin
               tmr_nxt = tmr_r + 1'b1; // [R14]
            end else if (!fifo_out_valid) begin
               st_nxt = lerbs_pkg::LERBS_DOWN;
            end
         end
         lerbs_pkg::LERBS_DOWN: begin
            pres_v_nxt = 1'b0;
            if (host_startup) begin
               st_nxt = lerbs_pkg::LERBS_RUN; // [R22]
            end
         end
         default: begin
            st_nxt = lerbs_pkg::LERBS_DOWN;
         end
      endcase
      down_nxt = (st_nxt == lerbs_pkg::LERBS_DOWN);
   end

   always_comb begin
      halt_d_nxt = host_halt;
      rpriv_nxt = run && host_halt && !halt_d_r; // [R17]
      rpool_nxt = run && host_global_halt;
      cnt_nxt = cnt_r;
      for (int i = 0; i < NC; i++) begin
         if (host_cnt_clear && run && host_cnt_sel == 3'(i)
             && i != `LERBS_CNT_THR) begin
            cnt_nxt[i] = `LERBS_CNT_RST; // [R21]
         end
         if (cnt_inc[i] && run && !host_halt) begin // [R1]
            if (cnt_r[i] == cnt_max(i)) begin
               cnt_nxt[i] = `LERBS_CNT_RST; // [R21]
            end else begin
               cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
         end
      end
      cdat_nxt = '0;
      if (host_cnt_sel < 3'(NC)) begin
         cdat_nxt = cnt_r[host_cnt_sel];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= lerbs_pkg::LERBS_RUN;
         down_r <= 1'b0;
         tmr_r <= '0;
         stage_v_r <= 1'b0;
         stage_r <= '0;
         pres_v_r <= 1'b0;
         pres_r <= '0;
         irq_r <= 1'b0;
         halt_d_r <= 1'b0;
         rpriv_r <= 1'b0;
         rpool_r <= 1'b0;
         cnt_r <= '0;
         cdat_r <= 16'h0000;
      end else begin
         st_r <= st_nxt;
         down_r <= down_nxt;
         tmr_r <= tmr_nxt;
         stage_v_r <= stage_v_nxt;
         stage_r <= stage_nxt;
         pres_v_r <= pres_v_nxt;
         pres_r <= pres_nxt;
         irq_r <= irq_nxt;
         halt_d_r <= halt_d_nxt;
         rpriv_r <= rpriv_nxt;
         rpool_r <= rpool_nxt;
         cnt_r <= cnt_nxt;
         cdat_r <= cdat_nxt;
      end
   end

   assign buf_sel = sel;
   assign resp_valid = pres_v_r;
   assign resp_data = pres_r;
   assign host_irq = irq_r;
   assign dev_shutdown = down_r;
   assign ret_priv_bufs = rpriv_r;
   assign ret_pool_bufs = rpool_r;
   assign cnt_data = cdat_r;

   sequence s_present;
      load ##1 (pres_v_r && irq_r);
   endsequence

   a_counter_freeze: assert property (@(posedge core_clk) disable iff (!rst_n)
      (host_halt && !host_cnt_clear) |=> (cnt_r == $past(cnt_r)))
      else $error("counter moved while halted"); // [R1]
   a_info_class: assert property (@(posedge core_clk) disable iff (!rst_n)
      (stage_v_r && stage_r.code >= `LERBS_INFO_LO
      && stage_r.code <= `LERBS_INFO_HI)
      |-> stage_r.cls == lerbs_pkg::LERBS_CL_INFO)
      else $error("info code misclassified"); // [R2]
   a_nxm_report: assert property (@(posedge core_clk) disable iff (!rst_n)
      (run && nxm_valid && !overflow) |=> (stage_v_r
      && stage_r.code == `LERBS_CODE_NXM && stage_r.data == $past(nxm_addr)
      && stage_r.cls == lerbs_pkg::LERBS_CL_RECOV))
      else $error("bad address response missing"); // [R5]
   a_thr_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cnt_r[`LERBS_CNT_THR] <= `LERBS_MAX_THR)
      and (run && !host_halt && cnt_inc[`LERBS_CNT_THR]
      && cnt_r[`LERBS_CNT_THR] == `LERBS_MAX_THR
      |=> cnt_r[`LERBS_CNT_THR] == `LERBS_CNT_RST))
      else $error("threshold counter did not wrap"); // [R21]
   a_ovf_drain: assert property (@(posedge core_clk) disable iff (!rst_n)
      overflow |=> (st_r == lerbs_pkg::LERBS_DRAIN))
      else $error("overflow did not start drain"); // [R13]
   a_drain_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == lerbs_pkg::LERBS_DRAIN && load) |-> s_present)
      else $error("drain response not presented"); // [R14]
   a_win_fresh: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == lerbs_pkg::LERBS_DRAIN && load) |=> tmr_r == '0)
      else $error("window not restarted"); // [R15]
   a_win_expire: assert property (@(posedge core_clk) disable iff (!rst_n)
      (st_r == lerbs_pkg::LERBS_DRAIN && pres_v_r && !host_resp_ack
      && !load && tmr_r == TW'(WIN_CYC - 1)) |=> dev_shutdown)
      else $error("no shutdown after window"); // [R16]
   a_down_quiet: assert property (@(posedge core_clk) disable iff (!rst_n)
      (dev_shutdown && !host_startup) |=> (dev_shutdown && !stage_v_r
      && !ret_priv_bufs && buf_sel == '0))
      else $error("activity while shut down"); // [R22]
   a_halt_return: assert property (@(posedge core_clk) disable iff (!rst_n)
      (run && host_halt && !halt_d_r) |=> ret_priv_bufs ##1 !ret_priv_bufs)
      else $error("halt did not return buffers"); // [R17]
endmodule
`default_nettype wire

// *** rtl/lerbs_fifo.sv ***
`default_nettype none
module lerbs_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [0:DEPTH-1];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic wr, rd;

   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;

   function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
      inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
   endfunction

   always_comb begin
      wp_nxt = wr ? inc_ptr(wp_r) : wp_r;
      rp_nxt = rd ? inc_ptr(rp_r) : rp_r;
      cnt_nxt = cnt_r;
      if (wr && !rd) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (rd && !wr) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      if (flush) begin
         wp_nxt = '0;
         rp_nxt = '0;
         cnt_nxt = '0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (wr) begin
         mem_r[wp_r] <= in_data;
      end
   end
endmodule
`default_nettype wire

// *** rtl/lerbs_pkg.sv ***
`default_nettype none
package lerbs_pkg;
   typedef enum logic [1:0] {
      LERBS_CL_INFO,
      LERBS_CL_RECOV,
      LERBS_CL_NET
   } lerbs_class_type;
   typedef struct packed {
      lerbs_class_type cls;
      logic [8:0] code;
      logic [17:0] data;
   } lerbs_resp_type;
   typedef struct packed {
      logic avail;
      logic [15:0] size;
   } lerbs_list_type;
   typedef struct packed {
      logic seq_ok;
      logic [15:0] len;
   } lerbs_msg_type;
   typedef struct packed {
      logic ignored;
      logic take_pool;
      logic take_priv;
      logic nak_unavail;
      logic nak_small;
   } lerbs_sel_type;
   typedef enum logic [1:0] {
      LERBS_RUN,
      LERBS_DRAIN,
      LERBS_DOWN
   } lerbs_state_type;
endpackage
`default_nettype wire

// *** tb/lerbs_host_model.sv ***
`default_nettype none
module lerbs_host_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ack_en,
   input wire logic [3:0] delay,
   input wire logic resp_valid,
   output logic host_resp_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_r;
   // reads each presented response after a chosen delay
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 4'h0;
         host_resp_ack <= 1'b0;
      end else begin
         host_resp_ack <= 1'b0;
         if (!resp_valid || host_resp_ack) begin
            wait_r <= 4'h0;
         end else if (ack_en && wait_r >= delay) begin
            host_resp_ack <= 1'b1;
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic host_startup = 1'b0;
   logic host_halt = 1'b0;
   logic host_global_halt = 1'b0;
   logic host_resp_ack;
   logic [2:0] host_cnt_sel = 3'h0;
   logic host_cnt_clear = 1'b0;
   logic line_msg_valid = 1'b0;
   lerbs_pkg::lerbs_msg_type line_msg = '0;
   logic pool_en = 1'b0;
   logic pool_quota_nz = 1'b0;
   lerbs_pkg::lerbs_list_type pool_head = '0;
   lerbs_pkg::lerbs_list_type priv_head = '0;
   logic nxm_valid = 1'b0;
   logic [17:0] nxm_addr = 18'h00000;
   logic proc_err_valid = 1'b0;
   logic [8:0] proc_err_code = 9'h000;
   logic [4:0] cnt_inc = 5'h00;
   lerbs_pkg::lerbs_sel_type buf_sel;
   logic resp_valid;
   lerbs_pkg::lerbs_resp_type resp_data;
   logic host_irq, dev_shutdown, ret_priv_bufs, ret_pool_bufs;
   logic [15:0] cnt_data;
   logic ack_en = 1'b1;
   logic [3:0] delay = 4'h2;
   int err_count = 0;
   int n_tests = 0;
   int i, k, got;
   logic seen;
   lerbs_pkg::lerbs_sel_type es;
   logic [8:0] codes [8] = '{9'h064, 9'h08c, 9'h063, 9'h08d,
                             9'h12c, 9'h12e, 9'h12d, 9'h0c8};

   always #10 core_clk = ~core_clk;

   lerbs_ctrl #(.WIN_CYC(20), .DEPTH(8)) DUT (.core_clk(core_clk),
      .rst_n(rst_n), .host_startup(host_startup), .host_halt(host_halt),
      .host_global_halt(host_global_halt), .host_resp_ack(host_resp_ack),
      .host_cnt_sel(host_cnt_sel), .host_cnt_clear(host_cnt_clear),
      .line_msg_valid(line_msg_valid), .line_msg(line_msg),
      .pool_en(pool_en), .pool_quota_nz(pool_quota_nz),
      .pool_head(pool_head), .priv_head(priv_head), .nxm_valid(nxm_valid),
      .nxm_addr(nxm_addr), .proc_err_valid(proc_err_valid),
      .proc_err_code(proc_err_code), .cnt_inc(cnt_inc), .buf_sel(buf_sel),
      .resp_valid(resp_valid), .resp_data(resp_data), .host_irq(host_irq),
      .dev_shutdown(dev_shutdown), .ret_priv_bufs(ret_priv_bufs),
      .ret_pool_bufs(ret_pool_bufs), .cnt_data(cnt_data));

   lerbs_host_model host (.core_clk(core_clk), .rst_n(rst_n),
      .ack_en(ack_en), .delay(delay), .resp_valid(resp_valid),
      .host_resp_ack(host_resp_ack));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic tick;
      @(negedge core_clk);
   endtask

   function automatic lerbs_pkg::lerbs_sel_type exp_sel;
      lerbs_pkg::lerbs_sel_type s;
      logic u;
      s = '0;
      u = pool_en && pool_quota_nz && pool_head.avail;
      if (!line_msg.seq_ok) s.ignored = 1'b1;
      else if (u && pool_head.size >= line_msg.len) s.take_pool = 1'b1;
      else if (priv_head.avail && priv_head.size >= line_msg.len)
         s.take_priv = 1'b1;
      else if (u || priv_head.avail) s.nak_small = 1'b1;
      else s.nak_unavail = 1'b1;
      return s;
   endfunction

   function automatic logic [1:0] exp_cls(input logic [8:0] c);
      if (c >= 9'h064 && c <= 9'h08c) return 2'(lerbs_pkg::LERBS_CL_INFO);
      if (c == 9'h12c || c == 9'h12e) return 2'(lerbs_pkg::LERBS_CL_RECOV);
      return 2'(lerbs_pkg::LERBS_CL_NET);
   endfunction

   task automatic send_err(input logic [8:0] c);
      proc_err_valid = 1'b1;
      proc_err_code = c;
      tick();
      proc_err_valid = 1'b0;
   endtask

   task automatic wait_irq;
      k = 0;
      while (host_irq !== 1'b1 && k < 50) begin
         tick();
         k++;
      end
      check(32'(host_irq), 32'h1);
   endtask

   task automatic pulse_cnt(input int idx, input int n, input int e);
      if (n > 0) begin
         cnt_inc = 5'(1 << idx);
         repeat (n) tick();
         cnt_inc = 5'h00;
      end
      repeat (2) tick();
      check(32'(cnt_data), 32'(e));
   endtask

   task automatic fill_queue;
      ack_en = 1'b0;
      proc_err_valid = 1'b1;
      for (i = 0; i < 12; i++) begin
         proc_err_code = 9'h0c8 + 9'(i);
         tick();
      end
      proc_err_valid = 1'b0;
   endtask

   task automatic restart;
      host_startup = 1'b1;
      tick();
      host_startup = 1'b0;
      tick();
      check(32'(dev_shutdown), 32'h0);
      ack_en = 1'b1;
   endtask

   initial begin
      #400000;
      err_count++;
      report_and_stop();
   end

   initial begin
      void'($urandom(32'h88515686));
      repeat (3) tick();
      rst_n = 1'b1;
      check(32'({resp_valid, host_irq, dev_shutdown, buf_sel}), 32'h0);
      delay = 4'h0;
      line_msg_valid = 1'b1;
      for (i = 0; i < 300; i++) begin
         line_msg.seq_ok = ($urandom_range(0, 7) != 0);
         line_msg.len = 16'($urandom_range(0, 15));
         pool_en = 1'($urandom);
         pool_quota_nz = ($urandom_range(0, 3) != 0);
         pool_head = {1'($urandom), 16'($urandom_range(0, 15))};
         priv_head = {1'($urandom), 16'($urandom_range(0, 15))};
         es = exp_sel();
         tick();
         check(32'(buf_sel), 32'(es));
      end
      line_msg_valid = 1'b0;
      repeat (40) tick();
      line_msg = {1'b1, 16'h0005};
      pool_en = 1'b0;
      priv_head = {1'b1, 16'h0001};
      line_msg_valid = 1'b1;
      tick();
      line_msg_valid = 1'b0;
      check(32'(buf_sel), 32'h01);
      wait_irq();
      check(32'({resp_data.cls, resp_data.code}),
         32'({2'(lerbs_pkg::LERBS_CL_RECOV), 9'h12e}));
      repeat (6) tick();
      for (i = 0; i < 8; i++) begin
         send_err(codes[i]);
         wait_irq();
         check(32'(resp_data.cls), 32'(exp_cls(codes[i])));
         check(32'(resp_data.code), 32'(codes[i]));
         repeat (6) tick();
      end
      nxm_addr = 18'($urandom);
      nxm_valid = 1'b1;
      proc_err_valid = 1'b1;
      tick();
      nxm_valid = 1'b0;
      proc_err_valid = 1'b0;
      wait_irq();
      check(32'(resp_data), 32'({2'(lerbs_pkg::LERBS_CL_RECOV), 9'h12c,
         nxm_addr}));
      host_halt = 1'b1;
      seen = 1'b0;
      repeat (2) begin
         tick();
         seen = seen | ret_priv_bufs;
      end
      check(32'(seen), 32'h1);
      host_global_halt = 1'b1;
      tick();
      host_global_halt = 1'b0;
      seen = ret_pool_bufs;
      tick();
      check(32'(seen | ret_pool_bufs), 32'h1);
      host_halt = 1'b0;
      repeat (6) tick();
      host_cnt_sel = 3'h0;
      pulse_cnt(0, 3, 3);
      host_halt = 1'b1;
      pulse_cnt(0, 2, 3);
      host_cnt_sel = 3'h4;
      pulse_cnt(4, 2, 0);
      host_halt = 1'b0;
      pulse_cnt(4, 2, 2);
      host_cnt_clear = 1'b1;
      tick();
      host_cnt_clear = 1'b0;
      pulse_cnt(4, 0, 0);
      host_cnt_sel = 3'h3;
      pulse_cnt(3, 7, 7);
      host_cnt_clear = 1'b1;
      tick();
      host_cnt_clear = 1'b0;
      pulse_cnt(3, 0, 7);
      pulse_cnt(3, 1, 0);
      fill_queue();
      repeat (4) tick();
      check(32'(resp_data.code), 32'h0c8);
      delay = 4'h1;
      ack_en = 1'b1;
      got = 1;
      k = 0;
      while (dev_shutdown !== 1'b1 && k < 300) begin
         tick();
         k++;
         if (host_irq === 1'b1) begin
            check(32'(resp_data.code), 32'h0c8 + 32'(got));
            got++;
         end
      end
      check(32'(got), 32'h9);
      check(32'({dev_shutdown, resp_valid}), 32'h2);
      line_msg_valid = 1'b1;
      tick();
      line_msg_valid = 1'b0;
      check(32'(buf_sel), 32'h0);
      send_err(9'h0c8);
      repeat (5) tick();
      check(32'(resp_valid), 32'h0);
      restart();
      fill_queue();
      k = 0;
      while (dev_shutdown !== 1'b1 && k < 60) begin
         tick();
         k++;
      end
      check(32'(k >= 5 && k <= 30), 32'h1);
      restart();
      report_and_stop();
   end
endmodule
`default_nettype wire
